// [timer_path_pkg.sv]
// Shared constants and carrier types for the three-channel timer data path.
// Assumes one system clock; all host and counter pins arrive asynchronously.
package timer_path_pkg;

   // Channel count and port codes
   localparam int CHANNELS = 3;
   localparam logic [1:0] PORT_SETUP = 2'h3;

   // Mode setup word field positions
   localparam int CW_PICK_HI = 7;
   localparam int CW_PICK_LO = 6;
   localparam int CW_FMT_HI = 5;
   localparam int CW_FMT_LO = 4;

   // Byte format codes
   localparam logic [1:0] FMT_LATCH = 2'h0;
   localparam logic [1:0] FMT_LOW = 2'h1;
   localparam logic [1:0] FMT_HIGH = 2'h2;
   localparam logic [1:0] FMT_BOTH = 2'h3;

   // Reset values
   localparam logic [5:0] SETUP_RESET = 6'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // Host pins grouped as they arrive
   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic [1:0] port_select;
      logic [7:0] host_data_bus;
   } host_pins_s;

   // Counter pins grouped per channel
   typedef struct packed {
      logic [CHANNELS-1:0] count_clock;
      logic [CHANNELS-1:0] gate;
   } count_pins_s;

   // Whole state of one counter channel
   typedef struct packed {
      logic [5:0] setup;
      logic [15:0] count;
      logic [15:0] read_hold_latch;
      logic frozen;
      logic [7:0] preload_high;
      logic [7:0] preload_low;
      logic read_next_high;
      logic write_next_high;
      logic load_pending;
      logic null_count;
      logic out_level;
      logic [7:0] status;
   } channel_state_s;

endpackage

// [counter_channel.sv]
// One counter channel: counting element, read hold latch, preload register.
// Assumes strobes are single-cycle pulses already synchronised by the top.
`timescale 1ns/1ps
`default_nettype none
module counter_channel (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic tick_i,
   input wire logic gate_i,
   input wire logic setup_wr_i,
   input wire logic latch_cmd_i,
   input wire logic [5:0] setup_i,
   input wire logic data_wr_i,
   input wire logic [7:0] data_i,
   input wire logic data_rd_i,
   output logic [7:0] byte_o,
   output logic out_o,
   output logic [7:0] status_o
);
   timer_path_pkg::channel_state_s s_q, s_d;
   logic [1:0] fmt;

   assign fmt = s_q.setup[timer_path_pkg::CW_FMT_HI:
                          timer_path_pkg::CW_FMT_LO];

   // Next byte offered to the host, always from the hold latch
   always_comb begin
      byte_o = s_q.read_hold_latch[7:0];
      if (fmt == timer_path_pkg::FMT_HIGH ||
          (fmt == timer_path_pkg::FMT_BOTH && s_q.read_next_high)) begin
         byte_o = s_q.read_hold_latch[15:8];
      end
   end

   assign out_o = s_q.out_level;
   assign status_o = s_q.status;

   // Channel next-state logic
   always_comb begin
      s_d = s_q;
      // Counting element ticks on its own clock edge
      if (tick_i) begin
         if (s_q.load_pending) begin
            s_d.count = {s_q.preload_high, s_q.preload_low};
            s_d.load_pending = 1'b0;
            s_d.null_count = 1'b0;
            s_d.out_level = 1'b0;
         end else if (gate_i) begin
            s_d.count = s_q.count - 16'h0001;
            if (s_q.count == 16'h0001) begin
               s_d.out_level = 1'b1;
            end
         end
      end
      // Hold latch follows unless frozen
      if (!s_q.frozen) begin
         s_d.read_hold_latch = s_q.count;
      end
      // Host read advances byte order and releases the latch
      if (data_rd_i) begin
         if (fmt == timer_path_pkg::FMT_BOTH && !s_q.read_next_high) begin
            s_d.read_next_high = 1'b1;
         end else begin
            s_d.read_next_high = 1'b0;
            s_d.frozen = 1'b0;
         end
      end
      // Latch after the read, so a fresh freeze wins over a release
      if (latch_cmd_i && !s_q.frozen) begin
         s_d.read_hold_latch = s_q.count;
         s_d.frozen = 1'b1;
      end
      if (latch_cmd_i) begin
         s_d.status = {s_q.out_level, s_q.null_count, s_q.setup};
      end
      // Host write goes only into the preload register
      if (data_wr_i) begin
         s_d.null_count = 1'b1;
         if (fmt == timer_path_pkg::FMT_HIGH ||
             (fmt == timer_path_pkg::FMT_BOTH && s_q.write_next_high)) begin
            s_d.preload_high = data_i;
         end else begin
            s_d.preload_low = data_i;
         end
         if (fmt == timer_path_pkg::FMT_BOTH && !s_q.write_next_high) begin
            s_d.write_next_high = 1'b1;
         end else begin
            s_d.write_next_high = 1'b0;
            s_d.load_pending = 1'b1;
         end
      end
      // Reprogramming resets byte order and releases any frozen count
      if (setup_wr_i) begin
         s_d.setup = setup_i;
         s_d.read_next_high = 1'b0;
         s_d.write_next_high = 1'b0;
         s_d.frozen = 1'b0;
         s_d.load_pending = 1'b0;
         s_d.null_count = 1'b1;
         if (setup_i[timer_path_pkg::CW_FMT_HI:timer_path_pkg::CW_FMT_LO] !=
             timer_path_pkg::FMT_BOTH) begin
            s_d.preload_high = timer_path_pkg::BYTE_RESET;
            s_d.preload_low = timer_path_pkg::BYTE_RESET;
         end
      end
   end

   // State register
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '{setup: timer_path_pkg::SETUP_RESET,
                  count: timer_path_pkg::COUNT_RESET,
                  read_hold_latch: timer_path_pkg::COUNT_RESET,
                  frozen: 1'b0,
                  preload_high: timer_path_pkg::BYTE_RESET,
                  preload_low: timer_path_pkg::BYTE_RESET,
                  read_next_high: 1'b0,
                  write_next_high: 1'b0,
                  load_pending: 1'b0,
                  null_count: 1'b1,
                  out_level: 1'b0,
                  status: timer_path_pkg::BYTE_RESET};
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end
endmodule // counter_channel
`default_nettype wire

// [counter_latch_preload_path.sv]
// Top of the three-channel timer data path: host port and channel decode.
// Assumes host and counter pins are asynchronous to clock_i (25 MHz).
// Summary of operation
// - Strobes act only while chip select is low.
// - Port select picks one of three counters or mode setup.
// - Latched status holds setup bits, output level and null count.
// - Each counter has a 16-bit presettable down-counting element.
// - Hold latch has two byte halves tracking the count.
// - Latch command freezes count until read, then tracking resumes.
// - Only one hold latch half drives the byte bus at once.
// - Reads always return the hold latch, never the counter.
// - Written counts go to preload, then into the counter.
// - Preload has two halves, one loaded per write.
// - Preload moves both bytes into the counter together.
// - Single-byte formats clear both preload halves.
// - Host writes never reach the counting element directly.
// - Clock, gate and output pass through the channel logic only.
// - Exactly four ports: three counters and mode setup.
// - Both port select lines high address mode setup.
// - Setup word with format bits zero is a latch command.
// - Repeated latch before reading keeps the held count; status is latched again.
// - Format field picks low, high, or low-then-high bytes.
`timescale 1ns/1ps
`default_nettype none
module counter_latch_preload_path (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic cs_n_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic [1:0] port_select_i,
   input wire logic [7:0] host_data_bus_i,
   output logic [7:0] host_data_bus_o,
   output logic host_data_bus_oe_o,
   input wire logic [timer_path_pkg::CHANNELS-1:0] count_clock_i,
   input wire logic [timer_path_pkg::CHANNELS-1:0] gate_i,
   output logic [timer_path_pkg::CHANNELS-1:0] out_o,
   output logic [7:0] status0_o,
   output logic [7:0] status1_o,
   output logic [7:0] status2_o
);
   localparam int N = timer_path_pkg::CHANNELS;

   // Whole top-level state
   typedef struct packed {
      timer_path_pkg::host_pins_s host_meta;
      timer_path_pkg::host_pins_s host_sync;
      timer_path_pkg::host_pins_s host_prev;
      timer_path_pkg::count_pins_s pins_meta;
      timer_path_pkg::count_pins_s pins_sync;
      logic [N-1:0] clock_prev;
      logic [7:0] read_data;
      logic reading;
   } top_state_s;

   top_state_s s_q, s_d;
   timer_path_pkg::host_pins_s h;
   logic rd_start, wr_start, setup_write, latch_cmd;
   logic [1:0] pick;
   logic [N-1:0] tick, ch_setup_wr, ch_latch, ch_data_wr, ch_data_rd;
   logic [7:0] ch_byte [N];
   logic [7:0] ch_status [N];
   logic [7:0] sel_byte;

   // Port decode used for reads and writes alike
   function automatic logic port_hits(input logic [1:0] port, input int ch);
      port_hits = (port == ch[1:0]);
   endfunction

   // Access starts on the synchronised strobe falling edge
   assign h = s_q.host_sync;
   assign rd_start = !h.cs_n && !h.rd_n && s_q.host_prev.rd_n;
   assign wr_start = !h.cs_n && !h.wr_n && s_q.host_prev.wr_n;
   assign setup_write = wr_start &&
                        (h.port_select == timer_path_pkg::PORT_SETUP);
   assign pick = h.host_data_bus[timer_path_pkg::CW_PICK_HI:
                                 timer_path_pkg::CW_PICK_LO];
   assign latch_cmd = setup_write &&
      (h.host_data_bus[timer_path_pkg::CW_FMT_HI:timer_path_pkg::CW_FMT_LO]
       == timer_path_pkg::FMT_LATCH);

   // Per-channel strobes and counter clock edges
   generate
      for (genvar c = 0; c < N; c++) begin : g_ch
         assign tick[c] = s_q.pins_sync.count_clock[c] && !s_q.clock_prev[c];
         assign ch_setup_wr[c] = setup_write && !latch_cmd &&
                                 port_hits(pick, c);
         assign ch_latch[c] = latch_cmd && port_hits(pick, c);
         assign ch_data_wr[c] = wr_start &&
                                port_hits(h.port_select, c);
         assign ch_data_rd[c] = rd_start &&
                                port_hits(h.port_select, c);
         counter_channel u_channel (
            .clock_i(clock_i),
            .rst_n_i(rst_n_i),
            .ce_i(ce_i),
            .tick_i(tick[c]),
            .gate_i(s_q.pins_sync.gate[c]),
            .setup_wr_i(ch_setup_wr[c]),
            .latch_cmd_i(ch_latch[c]),
            .setup_i(h.host_data_bus[5:0]),
            .data_wr_i(ch_data_wr[c]),
            .data_i(h.host_data_bus),
            .data_rd_i(ch_data_rd[c]),
            .byte_o(ch_byte[c]),
            .out_o(out_o[c]),
            .status_o(ch_status[c])
         );
      end
   endgenerate

   // Byte of the addressed channel
   always_comb begin
      sel_byte = timer_path_pkg::BYTE_RESET;
      for (int c = 0; c < N; c++) begin
         if (port_hits(h.port_select, c)) begin
            sel_byte = ch_byte[c];
         end
      end
   end

   // Next state: synchronisers, read capture
   always_comb begin
      s_d = s_q;
      s_d.host_meta = '{cs_n: cs_n_i, rd_n: rd_n_i, wr_n: wr_n_i,
                        port_select: port_select_i,
                        host_data_bus: host_data_bus_i};
      s_d.host_sync = s_q.host_meta;
      s_d.host_prev = s_q.host_sync;
      s_d.pins_meta = '{count_clock: count_clock_i, gate: gate_i};
      s_d.pins_sync = s_q.pins_meta;
      s_d.clock_prev = s_q.pins_sync.count_clock;
      if (rd_start && h.port_select != timer_path_pkg::PORT_SETUP) begin
         s_d.read_data = sel_byte;
         s_d.reading = 1'b1;
      end
      if (h.cs_n || h.rd_n) begin
         s_d.reading = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '{host_meta: '{1'b1, 1'b1, 1'b1, 2'h0, 8'h00},
                  host_sync: '{1'b1, 1'b1, 1'b1, 2'h0, 8'h00},
                  host_prev: '{1'b1, 1'b1, 1'b1, 2'h0, 8'h00},
                  pins_meta: '{3'h0, 3'h0},
                  pins_sync: '{3'h0, 3'h0},
                  clock_prev: 3'h0,
                  read_data: timer_path_pkg::BYTE_RESET,
                  reading: 1'b0};
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   // Host bus and status outputs
   assign host_data_bus_o = s_q.read_data;
   assign host_data_bus_oe_o = s_q.reading;
   assign status0_o = ch_status[0];
   assign status1_o = ch_status[1];
   assign status2_o = ch_status[2];
endmodule // counter_latch_preload_path
`default_nettype wire

// [host_cpu_model.sv]
// Host CPU model: one peripheral bus access at a time, strobes held long.
// Assumes the device samples pins through synchronisers on clock_i.
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
   input wire logic clock_i,
   input wire logic [7:0] rdata_i,
   input wire logic oe_i,
   output timer_path_pkg::host_pins_s pins_o
);
   // Bus idle at time zero
   initial pins_o = '{1'b1, 1'b1, 1'b1, 2'h0, 8'h00};

   // One access; released data lines show the inverse of the last value
   task automatic acc(input logic wr, input logic cs_n, input logic [1:0] p,
      input logic [7:0] d, output logic [7:0] q, output logic oe);
      @(posedge clock_i);
      pins_o <= '{cs_n, wr, !wr, p, wr ? d : ~pins_o.host_data_bus};
      repeat (5) @(posedge clock_i);
      q = rdata_i;
      oe = oe_i;
      pins_o <= '{1'b1, 1'b1, 1'b1, p, ~pins_o.host_data_bus};
      repeat (4) @(posedge clock_i);
   endtask
endmodule // host_cpu_model
`default_nettype wire

// [counter_latch_preload_path_checker.sv]
// Checker on the data path ports: host bus answers and status timing.
// Assumes a single clock domain; bound to the path top below.
`timescale 1ns/1ps
`default_nettype none
module counter_latch_preload_path_checker (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic cs_n_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic [1:0] port_select_i,
   input wire logic [7:0] host_data_bus_o,
   input wire logic host_data_bus_oe_o,
   input wire logic [7:0] status0_o,
   input wire logic [7:0] status1_o,
   input wire logic [7:0] status2_o
);
   logic [3:0] since_setup_q;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   // Cycles since the last setup port write strobe
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i)
         since_setup_q <= 4'hF;
      else if (!cs_n_i && !wr_n_i && port_select_i == 2'h3)
         since_setup_q <= 4'h0;
      else if (since_setup_q != 4'hF)
         since_setup_q <= since_setup_q + 4'h1;
   end

   property p_cs_idle; cs_n_i [*4] |=> !host_data_bus_oe_o; endproperty
   a_cs_idle: assert property (p_cs_idle) else $error("bus driven unselected");
   property p_rd_idle; rd_n_i [*4] |=> !host_data_bus_oe_o; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("bus driven idle");
   property p_setup_port;
      (port_select_i == 2'h3) [*6] |-> !host_data_bus_oe_o;
   endproperty
   a_setup_port: assert property (p_setup_port) else $error("setup read");
   property p_answer;
      $fell(rd_n_i) && !cs_n_i && port_select_i != 2'h3
         |-> ##[1:5] host_data_bus_oe_o;
   endproperty
   a_answer: assert property (p_answer) else $error("no read answer");
   property p_hold;
      host_data_bus_oe_o && $past(host_data_bus_oe_o) |-> $stable(host_data_bus_o);
   endproperty
   a_hold: assert property (p_hold) else $error("read byte moved");
   property p_wr_quiet;
      (!wr_n_i && rd_n_i) [*5] |-> !host_data_bus_oe_o;
   endproperty
   a_wr_quiet: assert property (p_wr_quiet) else $error("bus driven on write");
   property p_st0; $changed(status0_o) |-> since_setup_q < 4'h8; endproperty
   a_st0: assert property (p_st0) else $error("status0 moved alone");
   property p_st1; $changed(status1_o) |-> since_setup_q < 4'h8; endproperty
   a_st1: assert property (p_st1) else $error("status1 moved alone");
   property p_st2; $changed(status2_o) |-> since_setup_q < 4'h8; endproperty
   a_st2: assert property (p_st2) else $error("status2 moved alone");
endmodule // counter_latch_preload_path_checker

bind counter_latch_preload_path counter_latch_preload_path_checker chk_u (
   .clock_i(clock_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .rd_n_i(rd_n_i),
   .wr_n_i(wr_n_i), .port_select_i(port_select_i),
   .host_data_bus_o(host_data_bus_o), .host_data_bus_oe_o(host_data_bus_oe_o),
   .status0_o(status0_o), .status1_o(status1_o), .status2_o(status2_o));
`default_nettype wire

// [counter_latch_preload_path_test.sv]
// Self-checking bench for the timer data path with a host model.
// Assumes the path top, its package and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module counter_latch_preload_path_test;
   logic clock_i, rst_n_i, oe, o, ce;
   logic [7:0] rdata, q;
   logic [7:0] st [3];
   logic [2:0] cclk, gate, out;
   timer_path_pkg::host_pins_s pins;
   int miscompares = 0;
   int num_checks = 0;
   // Rows: count written, status expected after latching
   logic [23:0] rows [3] = '{24'h1234_30, 24'hFFFF_30, 24'h0001_30};

   host_cpu_model host_u (.clock_i(clock_i), .rdata_i(rdata), .oe_i(oe),
      .pins_o(pins));
   counter_latch_preload_path dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .ce_i(ce), .cs_n_i(pins.cs_n), .rd_n_i(pins.rd_n),
      .wr_n_i(pins.wr_n), .port_select_i(pins.port_select),
      .host_data_bus_i(pins.host_data_bus), .host_data_bus_o(rdata),
      .host_data_bus_oe_o(oe), .count_clock_i(cclk), .gate_i(gate),
      .out_o(out), .status0_o(st[0]), .status1_o(st[1]), .status2_o(st[2]));

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [1:0] p, input logic [7:0] d);
      host_u.acc(1'b1, 1'b0, p, d, q, o);
   endtask

   task automatic rd(input logic [1:0] p, input logic [7:0] exp);
      host_u.acc(1'b0, 1'b0, p, 8'h00, q, o);
      chk({7'h00, o, q}, {8'h01, exp});
   endtask

   task automatic tick(input int ch);
      @(posedge clock_i);
      cclk[ch] <= 1'b1;
      repeat (4) @(posedge clock_i);
      cclk[ch] <= 1'b0;
      repeat (4) @(posedge clock_i);
   endtask

   // Free-running system clock
   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge clock_i);
      miscompares++;
      test_done;
   end

   // Main sequence
   initial begin
      rst_n_i = 1'b0;
      ce = 1'b1;
      cclk = 3'h0;
      gate = 3'h0;
      repeat (10) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      for (int i = 0; i < 3; i++) begin
         wr(2'h3, {2'(i), 6'h30});
         wr(2'(i), rows[i][15:8]);
         wr(2'(i), rows[i][23:16]);
         tick(i);
         wr(2'h3, {2'(i), 6'h00});
         rd(2'(i), rows[i][15:8]);
         rd(2'(i), rows[i][23:16]);
         chk({8'h00, st[i]}, {8'h00, rows[i][7:0]});
      end
      // Unselected strobes and setup port reads do nothing
      host_u.acc(1'b1, 1'b1, 2'h0, 8'h55, q, o);
      host_u.acc(1'b0, 1'b1, 2'h0, 8'h00, q, o);
      chk({15'h0000, o}, 16'h0000);
      host_u.acc(1'b0, 1'b0, 2'h3, 8'h00, q, o);
      chk({15'h0000, o}, 16'h0000);
      // Second latch ignored, then reads track again
      gate[0] <= 1'b1;
      wr(2'h3, 8'h00);
      tick(0);
      gate[0] <= 1'b0;
      wr(2'h3, 8'h00);
      rd(2'h0, 8'h34);
      rd(2'h0, 8'h12);
      rd(2'h0, 8'h33);
      rd(2'h0, 8'h12);
      // Count from one to zero, then wrap
      gate[2] <= 1'b1;
      tick(2);
      chk({15'h0000, out[2]}, 16'h0001);
      tick(2);
      gate[2] <= 1'b0;
      wr(2'h3, 8'h80);
      rd(2'h2, 8'hFF);
      rd(2'h2, 8'hFF);
      // Single-byte formats clear the unwritten preload half
      wr(2'h3, 8'h50);
      wr(2'h1, 8'hAB);
      tick(1);
      wr(2'h3, 8'h40);
      rd(2'h1, 8'hAB);
      wr(2'h3, 8'h60);
      wr(2'h1, 8'hCD);
      tick(1);
      wr(2'h3, 8'h40);
      rd(2'h1, 8'hCD);
      wr(2'h3, 8'h50);
      wr(2'h3, 8'h40);
      rd(2'h1, 8'h00);
      // Half a two-byte count must not load
      wr(2'h3, 8'h30);
      wr(2'h0, 8'h78);
      tick(0);
      wr(2'h3, 8'h00);
      rd(2'h0, 8'h33);
      rd(2'h0, 8'h12);
      wr(2'h0, 8'h56);
      tick(0);
      wr(2'h3, 8'h00);
      rd(2'h0, 8'h78);
      rd(2'h0, 8'h56);
      // Clock enable low freezes gate and counter clock sampling
      gate[0] <= 1'b1;
      ce <= 1'b0;
      tick(0);
      ce <= 1'b1;
      gate[0] <= 1'b0;
      wr(2'h3, 8'h00);
      rd(2'h0, 8'h78);
      rd(2'h0, 8'h56);
      // Reset mid-run returns every channel to its idle state
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      chk({8'h00, st[0]}, 16'h0000);
      chk({8'h00, st[1]}, 16'h0000);
      chk({8'h00, st[2]}, 16'h0000);
      chk({12'h000, oe, out}, 16'h0000);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      // Read-back pick is ignored, then a latch shows reset setup
      wr(2'h3, 8'hF0);
      wr(2'h3, 8'h00);
      chk({8'h00, st[0]}, 16'h0040);
      rd(2'h0, 8'h00);
      test_done;
   end
endmodule // counter_latch_preload_path_test
`default_nettype wire
